// ---- common/psmp_defines.vh ----
// Constants for the program sequencing and memory paging block.
// Assumes a single 10 MHz clock and an active-low asynchronous reset.
`ifndef PSMP_DEFINES_VH
`define PSMP_DEFINES_VH

`define PSMP_PC_W        13
`define PSMP_PAGE_OFS_W  11
`define PSMP_STACK_DEPTH 8
`define PSMP_SP_W        4
`define PSMP_TAB_W       15
`define PSMP_RAM_AW      10

// Fixed vectors
`define PSMP_VEC_RESET   13'h0000
`define PSMP_VEC_DIV0    13'h0004
`define PSMP_VEC_TMR0    13'h0008
`define PSMP_VEC_PORTRC  13'h000c
`define PSMP_VEC_DIV1    13'h0014
`define PSMP_VEC_TMR1    13'h0020

// Writable-bit masks for the paging registers
`define PSMP_ROMPG_MASK  4'h3
`define PSMP_IPAGE_MASK  4'h7
`define PSMP_WRP_MASK    4'hf
`define PSMP_BANK_MASK   4'h7
`define PSMP_REG_RST     4'h0

// Register selects on reg_sel
`define PSMP_SEL_ROMPG   3'h0
`define PSMP_SEL_IPAGE   3'h1
`define PSMP_SEL_WRP     3'h2
`define PSMP_SEL_BANK    3'h3
`define PSMP_SEL_TABLE_POINTER_LOW_NIBBLE    3'h4
`define PSMP_SEL_TAB1    3'h5
`define PSMP_SEL_TAB2    3'h6
`define PSMP_SEL_TAB3    3'h7

// RAM address modes
`define PSMP_AM_DIRECT   2'h0
`define PSMP_AM_INDIRECT 2'h1
`define PSMP_AM_WORKREG  2'h2

// Program counter commands
`define PSMP_CMD_STEP    3'h0
`define PSMP_CMD_JUMP    3'h1
`define PSMP_CMD_CALL    3'h2
`define PSMP_CMD_BRANCH  3'h3
`define PSMP_CMD_RETURN  3'h4
`define PSMP_CMD_HOLD    3'h5

`endif

// ---- rtl/psmp_stack.v ----
// Eight-level return stack with wrap-around overwrite.
// Assumes push and pop are never asserted in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_defines.vh"
module psmp_stack (
   input  wire                   clk,      // System clock
   input  wire                   rst_n,    // Async reset, low
   input  wire                   push,     // Push request
   input  wire                   pop,      // Pop request
   input  wire [`PSMP_PC_W-1:0]  push_data,// Value to push
   output wire [`PSMP_PC_W-1:0]  top_data, // Current top entry
   output reg  [`PSMP_SP_W-1:0]  depth     // Valid entries 0..8
);
   reg [`PSMP_PC_W-1:0] entry [0:`PSMP_STACK_DEPTH-1]; // Circular store
   reg [2:0]            top_idx;                       // Index of top
   wire [2:0]           next_idx = top_idx + 3'h1;     // Push slot
   genvar               g;

   ////////////////////////////////////////////////////////////////
   // Storage: circular, so a ninth push overwrites the oldest
   generate
      for (g = 0; g < `PSMP_STACK_DEPTH; g = g + 1) begin : gen_ent
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               entry[g] <= {`PSMP_PC_W{1'b0}};
            end else if (push && next_idx == g) begin
               entry[g] <= push_data;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Pointer and depth; full depth saturates, no error raised
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_idx <= 3'h7;
         depth   <= 4'h0;
      end else if (push) begin
         top_idx <= next_idx;
         if (depth != 4'h8) begin
            depth <= depth + 4'h1;
         end
      end else if (pop) begin
         top_idx <= top_idx - 3'h1;
         if (depth != 4'h0) begin
            depth <= depth - 4'h1;
         end
      end
   end

   assign top_data = entry[top_idx];
endmodule
`default_nettype wire

// ---- rtl/psmp_vector.v ----
// Interrupt priority encoder giving the fixed vector address.
// Assumes request bits are already enabled and qualified.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_defines.vh"
module psmp_vector (
   input  wire [4:0]             irq_req, // 0 div0 .. 4 tmr1
   output reg                    irq_any, // Any request pending
   output reg  [2:0]             irq_id,  // Winning source
   output reg  [`PSMP_PC_W-1:0]  irq_vec  // Its vector
);
   ////////////////////////////////////////////////////////////////
   // Fixed priority: lowest index wins
   always @* begin
      irq_any = |irq_req;
      irq_id  = 3'h0;
      irq_vec = `PSMP_VEC_RESET;
      if (irq_req[0]) begin
         irq_id  = 3'h0;
         irq_vec = `PSMP_VEC_DIV0;
      end else if (irq_req[1]) begin
         irq_id  = 3'h1;
         irq_vec = `PSMP_VEC_TMR0;
      end else if (irq_req[2]) begin
         irq_id  = 3'h2;
         irq_vec = `PSMP_VEC_PORTRC;
      end else if (irq_req[3]) begin
         irq_id  = 3'h3;
         irq_vec = `PSMP_VEC_DIV1;
      end else if (irq_req[4]) begin
         irq_id  = 3'h4;
         irq_vec = `PSMP_VEC_TMR1;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/psmp_core.v ----
// Program sequencing and memory paging: program counter, return stack,
// ROM page select, table pointer and data RAM address forming.
// Assumes the decoder issues one command per cycle and feeds ROM data.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_defines.vh"
module psmp_core (
   input  wire                     clk,          // System clock, 10 MHz
   input  wire                     rst_n,        // Async reset, low
   // Sequencing commands
   input  wire [2:0]               pc_cmd,       // Step/jump/call/...
   input  wire [`PSMP_PAGE_OFS_W-1:0] pc_target, // In-page target
   input  wire [4:0]               irq_req,      // Enabled int requests
   output reg                      irq_taken,    // Interrupt accepted
   output reg  [2:0]               irq_src,      // Accepted source
   output reg  [`PSMP_PC_W-1:0]    program_counter_bits, // Fetch addr
   output wire [`PSMP_SP_W-1:0]    stack_depth,  // Stack entries held
   // Paging register access
   input  wire                     reg_wr,       // Register write
   input  wire [2:0]               reg_sel,      // Register select
   input  wire [3:0]               reg_wdata,    // Write nibble
   output reg  [3:0]               reg_rdata,    // Read nibble
   output reg  [3:0]               rom_page_select,      // ROM page
   output reg  [3:0]               indirect_page_select, // Ind. page
   output reg  [3:0]               work_reg_page_select, // WR page
   output reg  [3:0]               data_bank_select,     // Bank
   // Table read
   input  wire                     table_read_instr, // Table fetch
   output wire [`PSMP_PC_W-1:0]    table_rom_addr,   // ROM word addr
   output wire [1:0]               table_nib_sel,    // Nibble in word
   input  wire [15:0]              rom_rdata,        // ROM word
   output reg                      table_valid,      // Nibble ready
   output reg  [3:0]               table_data,       // Fetched nibble
   // Data RAM addressing
   input  wire [1:0]               ram_mode,     // Direct/indirect/WR
   input  wire [6:0]               ram_offset,   // Offset in bank/page
   input  wire                     imm_op,       // Immediate operand
   output reg  [`PSMP_RAM_AW-1:0]  ram_addr,     // Physical address
   output reg                      imm_illegal   // Immediate to RAM
);
   ////////////////////////////////////////////////////////////////
   // Internal signals
   reg  [15:0]             table_ptr;   // Four pointer nibbles
   reg  [`PSMP_PC_W-1:0]   next_pc;     // Next program counter
   wire [`PSMP_PC_W-1:0]   pc_inc;      // Sequential address
   wire                    stk_push;    // Push to stack
   wire                    stk_pop;     // Pop from stack
   wire [`PSMP_PC_W-1:0]   stk_top;     // Return address
   wire                    v_any;       // Request pending
   wire [2:0]              v_id;        // Winning source
   wire [`PSMP_PC_W-1:0]   v_vec;       // Winning vector
   wire                    take_irq;    // Accept this cycle

   assign pc_inc = program_counter_bits + 13'h0001;

   psmp_vector u_vec (
      .irq_req (irq_req),
      .irq_any (v_any),
      .irq_id  (v_id),
      .irq_vec (v_vec)
   );

   // Interrupts are accepted only between ordinary commands,
   // never while the decoder holds the counter
   assign take_irq = v_any && (pc_cmd != `PSMP_CMD_HOLD);
   assign stk_push = take_irq || (pc_cmd == `PSMP_CMD_CALL);
   assign stk_pop  = !take_irq && (pc_cmd == `PSMP_CMD_RETURN);

   psmp_stack u_stack (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (take_irq ? program_counter_bits : pc_inc),
      .top_data  (stk_top),
      .depth     (stack_depth)
   );

   ////////////////////////////////////////////////////////////////
   // Next program counter selection
   always @* begin
      next_pc = program_counter_bits;
      if (take_irq) begin
         next_pc = v_vec;
      end else begin
         case (pc_cmd)
            `PSMP_CMD_STEP: begin
               next_pc = pc_inc;
            end
            `PSMP_CMD_JUMP, `PSMP_CMD_CALL: begin
               // Page comes from the page register, not the PC
               next_pc = {rom_page_select[1:0], pc_target};
            end
            `PSMP_CMD_BRANCH: begin
               // Page register ignored: stays in the current page
               next_pc = {program_counter_bits[`PSMP_PC_W-1:`PSMP_PAGE_OFS_W],
                          pc_target};
            end
            `PSMP_CMD_RETURN: begin
               next_pc = stk_top;
            end
            `PSMP_CMD_HOLD: begin
               next_pc = program_counter_bits;
            end
            default: begin
               next_pc = program_counter_bits;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Program counter and interrupt acknowledge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         program_counter_bits <= `PSMP_VEC_RESET;
         irq_taken            <= 1'b0;
         irq_src              <= 3'h0;
      end else begin
         program_counter_bits <= next_pc;
         irq_taken            <= take_irq;
         irq_src              <= v_id;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Paging registers and table pointer nibbles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_page_select      <= `PSMP_REG_RST;
         indirect_page_select <= `PSMP_REG_RST;
         work_reg_page_select <= `PSMP_REG_RST;
         data_bank_select     <= `PSMP_REG_RST;
         table_ptr            <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_sel)
            `PSMP_SEL_ROMPG: begin
               rom_page_select <= reg_wdata & `PSMP_ROMPG_MASK;
            end
            `PSMP_SEL_IPAGE: begin
               indirect_page_select <= reg_wdata & `PSMP_IPAGE_MASK;
            end
            `PSMP_SEL_WRP: begin
               work_reg_page_select <= reg_wdata & `PSMP_WRP_MASK;
            end
            `PSMP_SEL_BANK: begin
               data_bank_select <= reg_wdata & `PSMP_BANK_MASK;
            end
            `PSMP_SEL_TABLE_POINTER_LOW_NIBBLE: begin
               table_ptr[3:0] <= reg_wdata;
            end
            `PSMP_SEL_TAB1: begin
               table_ptr[7:4] <= reg_wdata;
            end
            `PSMP_SEL_TAB2: begin
               table_ptr[11:8] <= reg_wdata;
            end
            `PSMP_SEL_TAB3: begin
               table_ptr[15:12] <= reg_wdata;
            end
            default: begin
               table_ptr <= table_ptr;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register read-back; top pointer bit is beyond 32768 but reads back as written
   always @* begin
      case (reg_sel)
         `PSMP_SEL_ROMPG: reg_rdata = rom_page_select;
         `PSMP_SEL_IPAGE: reg_rdata = indirect_page_select;
         `PSMP_SEL_WRP:   reg_rdata = work_reg_page_select;
         `PSMP_SEL_BANK:  reg_rdata = data_bank_select;
         `PSMP_SEL_TABLE_POINTER_LOW_NIBBLE:  reg_rdata = table_ptr[3:0];
         `PSMP_SEL_TAB1:  reg_rdata = table_ptr[7:4];
         `PSMP_SEL_TAB2:  reg_rdata = table_ptr[11:8];
         `PSMP_SEL_TAB3:  reg_rdata = table_ptr[15:12];
         default:         reg_rdata = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Table read: word address from pointer bits 14:2, nibble 1:0
   assign table_rom_addr = table_ptr[`PSMP_TAB_W-1:2];
   assign table_nib_sel  = table_ptr[1:0];

   // ROM answers combinationally; the nibble is registered here
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         table_valid <= 1'b0;
         table_data  <= 4'h0;
      end else begin
         table_valid <= table_read_instr;
         if (table_read_instr) begin
            case (table_nib_sel)
               2'h0:    table_data <= rom_rdata[3:0];
               2'h1:    table_data <= rom_rdata[7:4];
               2'h2:    table_data <= rom_rdata[11:8];
               default: table_data <= rom_rdata[15:12];
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Data RAM address forming
   always @* begin
      imm_illegal = 1'b0;
      case (ram_mode)
         `PSMP_AM_DIRECT: begin
            ram_addr = {data_bank_select[2:0], ram_offset};
            imm_illegal = imm_op;
         end
         `PSMP_AM_INDIRECT: begin
            ram_addr = {data_bank_select[2:0], indirect_page_select[2:0],
                        ram_offset[3:0]};
            imm_illegal = imm_op;
         end
         `PSMP_AM_WORKREG: begin
            // Working registers live in banks 0 and 1 regardless of bank
            ram_addr = {2'h0, work_reg_page_select, ram_offset[3:0]};
         end
         default: begin
            ram_addr = {data_bank_select[2:0], ram_offset};
            imm_illegal = imm_op;
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- test/psmp_asserts.sv ----
// Port-level checks for the sequencing and paging core.
// Assumes the shared header constants and a bind onto psmp_core.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_defines.vh"
module psmp_asserts (
   input wire logic        clk,                  // Clock
   input wire logic        rst_n,                // Reset, low
   input wire logic [2:0]  pc_cmd,               // Command
   input wire logic [10:0] pc_target,            // In-page target
   input wire logic [4:0]  irq_req,              // Requests
   input wire logic        irq_taken,            // Accepted
   input wire logic [2:0]  irq_src,              // Source
   input wire logic [12:0] program_counter_bits, // PC
   input wire logic [3:0]  stack_depth,          // Depth
   input wire logic [3:0]  rom_page_select,      // ROM page
   input wire logic [3:0]  indirect_page_select, // Ind. page
   input wire logic [3:0]  work_reg_page_select, // WR page
   input wire logic [3:0]  data_bank_select,     // Bank
   input wire logic        table_read_instr,     // Table fetch
   input wire logic [1:0]  table_nib_sel,        // Nibble select
   input wire logic [15:0] rom_rdata,            // ROM word
   input wire logic        table_valid,          // Nibble ready
   input wire logic [3:0]  table_data,           // Nibble
   input wire logic [1:0]  ram_mode,             // Address mode
   input wire logic [6:0]  ram_offset,           // Offset
   input wire logic        imm_op,               // Immediate
   input wire logic [9:0]  ram_addr,             // RAM address
   input wire logic        imm_illegal           // Immediate flag
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers: expected destinations, sampled one edge later via $past
   wire       no_irq = (irq_req == 5'h00);                            // Plain command
   wire [12:0] jdest = {rom_page_select[1:0], pc_target};             // Jump target
   wire [12:0] bdest = {program_counter_bits[12:11], pc_target};      // Branch target
   wire [15:0] sh    = rom_rdata >> {table_nib_sel, 2'b00};           // Nibble shift
   wire [3:0]  nib   = sh[3:0];                                       // Chosen nibble
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   step_count_a: assert property (pc_cmd == `PSMP_CMD_STEP && no_irq |=>
      program_counter_bits == $past(program_counter_bits) + 13'h1) else $error("step wrong");
   jump_page_a: assert property (pc_cmd == `PSMP_CMD_JUMP && no_irq |=>
      program_counter_bits == $past(jdest)) else $error("jump page wrong");
   branch_page_a: assert property (pc_cmd == `PSMP_CMD_BRANCH && no_irq |=>
      program_counter_bits == $past(bdest)) else $error("branch left page");
   call_push_a: assert property (pc_cmd == `PSMP_CMD_CALL && no_irq && stack_depth < 4'h8
      |=> stack_depth == $past(stack_depth) + 4'h1) else $error("call did not push");
   vector_first_a: assert property (irq_req[0] && pc_cmd != `PSMP_CMD_HOLD
      |=> program_counter_bits == `PSMP_VEC_DIV0 ##[0:1] (irq_taken && irq_src == 3'h0))
      else $error("divider vector wrong");
   vector_last_a: assert property (irq_req == 5'h10 && pc_cmd != `PSMP_CMD_HOLD
      |=> program_counter_bits == `PSMP_VEC_TMR1) else $error("timer vector wrong");
   hold_refuse_a: assert property (pc_cmd == `PSMP_CMD_HOLD
      |=> $stable(program_counter_bits)) else $error("hold moved pc");
   depth_cap_a: assert property (pc_cmd == `PSMP_CMD_CALL && no_irq && stack_depth == 4'h8
      |=> stack_depth == 4'h8) else $error("depth over eight");
   rsvd_zero_a: assert property (rom_page_select[3:2] == 2'h0 &&
      !indirect_page_select[3] && !data_bank_select[3]) else $error("reserved bit set");
   table_fetch_a: assert property (table_read_instr
      |=> table_valid && table_data == $past(nib)) else $error("table nibble wrong");
   wr_addr_a: assert property (ram_mode == `PSMP_AM_WORKREG
      |-> ram_addr == {2'b00, work_reg_page_select, ram_offset[3:0]}) else $error("wr addr");
   imm_flag_a: assert property (ram_mode == `PSMP_AM_DIRECT || ram_mode == `PSMP_AM_INDIRECT
      |-> imm_illegal == imm_op) else $error("immediate flag wrong");
   call_c: cover property (pc_cmd == `PSMP_CMD_CALL && no_irq);
   irq_c: cover property (irq_taken);
   table_c: cover property (table_valid);
endmodule
bind psmp_core psmp_asserts i_chk (.*);
`default_nettype wire

// ---- test/program_seq_mem_paging_tb.sv ----
// Self-checking bench for psmp_core: sequencing, stack, vectors, paging.
// Assumes the shared header and the checker bound onto the core.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_defines.vh"
module program_seq_mem_paging_tb;
   logic        clk, rst_n, reg_wr, table_read_instr, imm_op;   // Controls
   logic [2:0]  pc_cmd, reg_sel;                                // Command, select
   logic [10:0] pc_target;                                      // Target
   logic [4:0]  irq_req;                                        // Requests
   logic [3:0]  reg_wdata;                                      // Write nibble
   logic [15:0] rom_rdata;                                      // ROM word
   logic [1:0]  ram_mode;                                       // Address mode
   logic [6:0]  ram_offset;                                     // Offset
   wire         irq_taken, table_valid, imm_illegal;            // Flags
   wire  [2:0]  irq_src;                                        // Source
   wire  [12:0] program_counter_bits, table_rom_addr;           // Addresses
   wire  [3:0]  stack_depth, reg_rdata, table_data;             // Nibbles
   wire  [3:0]  rom_page_select, indirect_page_select;          // Pages
   wire  [3:0]  work_reg_page_select, data_bank_select;         // Pages
   wire  [1:0]  table_nib_sel;                                  // Nibble select
   wire  [9:0]  ram_addr;                                       // RAM address
   int          n_errors, checks_done;                          // Counters
   logic [12:0] vec [5] = '{`PSMP_VEC_DIV0, `PSMP_VEC_TMR0, `PSMP_VEC_PORTRC,
                            `PSMP_VEC_DIV1, `PSMP_VEC_TMR1};    // Vectors by priority
   psmp_core i_dut (.*);
   ////////////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Watchdog: whole run is about 120 cycles, limit is 3000
   initial begin
      #300000;
      n_errors++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One write strobe, then released a cycle later
   task automatic wr_reg(input logic [2:0] s, input logic [3:0] d);
      @(negedge clk) begin reg_wr = 1'b1; reg_sel = s; reg_wdata = d; end
      @(negedge clk) reg_wr = 1'b0;
   endtask
   // One command, then hold so the PC stays put for checking
   task automatic cmd(input logic [2:0] c, input logic [10:0] t, input logic [4:0] q);
      @(negedge clk) begin pc_cmd = c; pc_target = t; irq_req = q; end
      @(negedge clk) begin pc_cmd = `PSMP_CMD_HOLD; irq_req = 5'h00; end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      chk(program_counter_bits, `PSMP_VEC_RESET);
      chk({rom_page_select, indirect_page_select, work_reg_page_select,
           data_bank_select, stack_depth}, 16'h0);
      for (int s = 0; s < 4; s++) begin
         wr_reg(3'(s), 4'hf);
         chk(reg_rdata, 16'h7f73 >> (s * 4) & 16'hf);
      end
      chk({rom_page_select, indirect_page_select, work_reg_page_select,
           data_bank_select}, 16'h37f7);
   endtask
   task automatic t_jump;
      for (int p = 0; p < 4; p++) begin
         wr_reg(`PSMP_SEL_ROMPG, 4'(p));
         cmd(`PSMP_CMD_JUMP, 11'h7ff, 5'h00);
         chk(program_counter_bits, 16'h7ff + p * 16'h800);
      end
      wr_reg(`PSMP_SEL_ROMPG, 4'h0);
      cmd(`PSMP_CMD_BRANCH, 11'h123, 5'h00);
      chk(program_counter_bits, 16'h1923);
      cmd(`PSMP_CMD_STEP, 11'h0, 5'h00);
      chk(program_counter_bits, 16'h1924);
   endtask
   // Nine calls overflow the stack; pops come back newest first
   task automatic t_stack;
      for (int i = 1; i < 10; i++) begin
         cmd(`PSMP_CMD_CALL, 11'(i), 5'h00);
         chk(program_counter_bits, 16'(i));
         chk(stack_depth, (i > 8) ? 16'h8 : 16'(i));
      end
      for (int i = 9; i > 1; i--) begin
         cmd(`PSMP_CMD_RETURN, 11'h0, 5'h00);
         chk(program_counter_bits, 16'(i));
      end
      chk(stack_depth, 16'h0);
   endtask
   // Each source wins over all lower ones pending with it
   task automatic t_irq;
      logic [12:0] pre;
      for (int k = 0; k < 5; k++) begin
         pre = program_counter_bits;
         cmd(`PSMP_CMD_STEP, 11'h0, 5'h1f << k);
         chk(program_counter_bits, vec[k]);
         chk({irq_taken, irq_src}, {12'h0, 1'b1, 3'(k)});
         cmd(`PSMP_CMD_RETURN, 11'h0, 5'h00);
         chk(program_counter_bits, pre);
      end
      pre = program_counter_bits;
      cmd(`PSMP_CMD_HOLD, 11'h0, 5'h01);
      @(negedge clk);
      chk({irq_taken, program_counter_bits}, pre);
   endtask
   task automatic t_table;
      for (int i = 0; i < 4; i++)
         wr_reg(3'(`PSMP_SEL_TABLE_POINTER_LOW_NIBBLE + i), 4'(16'hda6b >> (i * 4)));
      chk({table_rom_addr, table_nib_sel}, 16'h5a6b);
      @(negedge clk) table_read_instr = 1'b1;
      @(negedge clk) table_read_instr = 1'b0;
      chk({table_valid, table_data}, 16'h14);
   endtask
   task automatic t_ram;
      logic [9:0] ea [3] = '{10'h2da, 10'h2ba, 10'h0ca};
      wr_reg(`PSMP_SEL_BANK, 4'h5);
      wr_reg(`PSMP_SEL_IPAGE, 4'h3);
      wr_reg(`PSMP_SEL_WRP, 4'hc);
      for (int m = 0; m < 3; m++) begin
         @(negedge clk) begin ram_mode = 2'(m); ram_offset = 7'h5a; imm_op = 1'b1; end
         #10 chk(ram_addr, ea[m]);
         chk(imm_illegal, (m < 2) ? 16'h1 : 16'h0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for ten cycles, then each scenario in turn
   initial begin
      {rst_n, reg_wr, table_read_instr, imm_op, reg_sel, reg_wdata} = '0;
      {pc_target, irq_req, ram_mode, ram_offset} = '0;
      pc_cmd = `PSMP_CMD_HOLD;
      rom_rdata = 16'h4321;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_regs();
      t_jump();
      t_stack();
      t_irq();
      t_table();
      t_ram();
      close_out();
   end
endmodule
`default_nettype wire
